//--- logic/rpe_cfg.svh
// Constants for the RSA primitive protocol data block engine and its controller
`ifndef RPE_CFG_SVH
`define RPE_CFG_SVH

// ----------------------------------------------------------------
// Parameter block field layout
// ----------------------------------------------------------------
`define RPE_FLAG_HI     31
`define RPE_FLAG_LO     23
`define RPE_LEN_A_HI    23
`define RPE_LEN_A_LO    12
`define RPE_LEN_B_HI    11
`define RPE_LEN_B_LO    0
`define RPE_LEN_W       12
`define RPE_SLOTS       9
`define RPE_NREF_4      4'h3
`define RPE_NREF_7      4'h6
`define RPE_NREF_9      4'h8
`define RPE_HI40_HI     7
`define RPE_HI36_HI     3
`define RPE_ADDR_W      40

// ----------------------------------------------------------------
// Controller register map (byte addresses)
// ----------------------------------------------------------------
`define RPE_REG_CTRL    8'h00
`define RPE_REG_STATUS  8'h04
`define RPE_REG_SCRATCH 8'h08
`define RPE_REG_COUNT   8'h0C
`define RPE_REG_BUF     8'h80
`define RPE_BUF_DEPTH   32
`define RPE_CNT_W       6
`define RPE_CNT_MAX     6'h20

// ----------------------------------------------------------------
// Control and status bit positions
// ----------------------------------------------------------------
`define RPE_C_START     0
`define RPE_C_OP        1
`define RPE_C_FORM_LO   2
`define RPE_C_FORM_HI   3
`define RPE_C_FMT       4
`define RPE_C_RNG       5
`define RPE_C_WRAP_LO   6
`define RPE_C_WRAP_HI   7
`define RPE_C_PS_LO     8
`define RPE_C_PS_HI     9
`define RPE_C_BLACK     10
`define RPE_S_BUSY      0
`define RPE_S_DONE      1

`endif

//--- logic/rpe_pkg.sv
// Types shared by both ends of the RSA parameter block link
package rpe_pkg;
  typedef enum logic {RPE_OP_ENC, RPE_OP_DEC} rpe_op_t;
  typedef enum logic [1:0] {RPE_FORM_1, RPE_FORM_2, RPE_FORM_3} rpe_form_t;
  typedef enum logic {RPE_FMT_NONE, RPE_FMT_PKCS15} rpe_fmt_t;
  typedef enum logic [1:0] {RPE_PS_32, RPE_PS_36, RPE_PS_40} rpe_ps_t;
  typedef enum logic [1:0] {RPE_M_ENC, RPE_M_F1, RPE_M_F2, RPE_M_F3} rpe_mode_t;
  typedef enum {
    RPE_ST_IDLE, RPE_ST_HDR, RPE_ST_W0, RPE_ST_REF_HI, RPE_ST_REF_LO, RPE_ST_TAIL,
    RPE_ST_DISP, RPE_ST_RNG, RPE_ST_KDEC, RPE_ST_MATH, RPE_ST_FIN
  } rpe_state_t;
  typedef enum {RPE_CS_IDLE, RPE_CS_START, RPE_CS_SEND, RPE_CS_WAIT} rpe_cstate_t;
endpackage

//--- logic/rpe_link_if.sv
// Link between the descriptor controller and the RSA parameter block engine
`timescale 1ns/100ps
`default_nettype none
interface rpe_link_if
  import rpe_pkg::*;
  ();
  logic      start;
  rpe_op_t   op;
  rpe_form_t form;
  rpe_fmt_t  fmt;
  logic      rng_sel;
  logic [1:0] wrap;
  rpe_ps_t   ps;
  logic      key_black;
  logic [31:0] word;
  logic      word_valid;
  logic      word_ready;
  logic      done;
  logic [31:0] scratch_reg_zero;

  modport device (
    input  start, op, form, fmt, rng_sel, wrap, ps, key_black, word, word_valid,
    output word_ready, done, scratch_reg_zero
  );
  modport ctrl (
    output start, op, form, fmt, rng_sel, wrap, ps, key_black, word, word_valid,
    input  word_ready, done, scratch_reg_zero
  );
endinterface
`default_nettype wire

//--- logic/rpe_engine.sv
// RSA public and private key primitive engine: parameter block parsing and sequencing
`timescale 1ns/100ps
`default_nettype none
`include "rpe_cfg.svh"
// Function
// - encrypt pads input per encoding selector
// - input is supplied or RNG-generated length bytes
// - generated input output uses wrap selector
// - encrypt lengths are right-aligned 12-bit counts
// - encrypt block: flags, lengths, four refs, tail
// - encrypt flag bits 31..28 pick indirection
// - references are 32, 36 or 40 bits
// - exponentiate then write result to output
// - decrypt unpads result per encoding selector
// - decrypt leaves plaintext length in scratch zero
// - black private components decrypted, modulus never
// - three private key forms accepted
// - form 1 block: flags, lengths, four refs
// - form 1 flag bits 31..28 pick indirection
// - form 2 block: seven refs, prime length tail
// - forms 2 and 3 still carry modulus length
// - scratch buffers at least prime sized
// - form 2 flag bits 31..25 pick indirection
// - form 3 uses reduced exponents and coefficient
// - form 3 block: nine refs, prime length tail
// - form 3 reduced lengths follow prime lengths
// - form 3 flag bits 31..23 pick indirection
// - parameter block follows descriptor header
module rpe_engine
  import rpe_pkg::*;
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Link to descriptor controller
  rpe_link_if.device             lnk,
  // Argument table
  output logic [`RPE_ADDR_W-1:0] arg_addr     [`RPE_SLOTS],
  output logic [`RPE_LEN_W-1:0]  arg_len      [`RPE_SLOTS],
  output logic [`RPE_SLOTS-1:0]  arg_indirect,
  output logic                   crt_mode,
  // Random input generation
  output logic                   rng_req,
  output logic [`RPE_LEN_W-1:0]  rng_len,
  output logic [1:0]             out_wrap,
  input  wire logic              rng_done,
  // Black key component unwrap
  output logic                   kdec_req,
  output logic [`RPE_SLOTS-1:0]  kdec_mask,
  input  wire logic              kdec_done,
  // Modular exponentiation
  output logic                   math_req,
  output logic                   math_dec,
  output logic                   pad_en,
  output logic                   unpad_en,
  input  wire logic              math_done,
  input  wire logic [`RPE_LEN_W-1:0] math_len
);

  // ----------------------------------------------------------------
  // Parse and sequence state
  // ----------------------------------------------------------------
  rpe_state_t state, next_state;
  rpe_mode_t  mode, next_mode;
  rpe_fmt_t   fmt, next_fmt;
  rpe_ps_t    ps, next_ps;
  logic       rng_sel, next_rng_sel, black, next_black;
  logic [1:0] wrap, next_wrap;
  logic [3:0] ref_idx, next_ref_idx, last_ref;
  logic [7:0] hi, next_hi;
  logic [`RPE_SLOTS-1:0] flags, next_flags;
  logic [`RPE_LEN_W-1:0] len_a, next_len_a, len_n, next_len_n;
  logic [`RPE_LEN_W-1:0] len_f, next_len_f, len_p, next_len_p, len_q, next_len_q;
  logic [`RPE_ADDR_W-1:0] addr [`RPE_SLOTS];
  logic [`RPE_ADDR_W-1:0] next_addr [`RPE_SLOTS];
  logic [31:0] scratch, next_scratch;
  logic        take;

  assign take = lnk.word_valid && lnk.word_ready;

  always_comb begin
    case (mode)
      RPE_M_F2: last_ref = `RPE_NREF_7;
      RPE_M_F3: last_ref = `RPE_NREF_9;
      default:  last_ref = `RPE_NREF_4;
    endcase
  end

  always_comb begin
    next_state   = state;
    next_mode    = mode;
    next_fmt     = fmt;
    next_ps      = ps;
    next_rng_sel = rng_sel;
    next_black   = black;
    next_wrap    = wrap;
    next_ref_idx = ref_idx;
    next_hi      = hi;
    next_flags   = flags;
    next_len_a   = len_a;
    next_len_n   = len_n;
    next_len_f   = len_f;
    next_len_p   = len_p;
    next_len_q   = len_q;
    next_addr    = addr;
    next_scratch = scratch;
    case (state)
      RPE_ST_IDLE: begin
        if (lnk.start) begin
          if (lnk.op == RPE_OP_ENC) begin
            next_mode = RPE_M_ENC;
          end else begin
            case (lnk.form)
              RPE_FORM_2: next_mode = RPE_M_F2;
              RPE_FORM_3: next_mode = RPE_M_F3;
              default:    next_mode = RPE_M_F1;
            endcase
          end
          next_fmt     = lnk.fmt;
          next_ps      = lnk.ps;
          next_rng_sel = lnk.rng_sel && (lnk.op == RPE_OP_ENC);
          next_black   = lnk.key_black;
          next_wrap    = lnk.wrap;
          next_state   = RPE_ST_HDR;
        end
      end
      RPE_ST_HDR: begin
        // Header word is skipped; the block starts right behind it
        if (take) begin
          next_state = RPE_ST_W0;
        end
      end
      RPE_ST_W0: begin
        if (take) begin
          // Flags are left-aligned, unused low bits are reserved
          next_flags   = lnk.word[`RPE_FLAG_HI:`RPE_FLAG_LO];
          next_len_a   = lnk.word[`RPE_LEN_A_HI:`RPE_LEN_A_LO];
          next_len_n   = lnk.word[`RPE_LEN_B_HI:`RPE_LEN_B_LO];
          next_ref_idx = '0;
          next_hi      = '0;
          next_state   = (ps == RPE_PS_32) ? RPE_ST_REF_LO : RPE_ST_REF_HI;
        end
      end
      RPE_ST_REF_HI: begin
        if (take) begin
          // Upper address word comes first; bits above the pointer width are dropped
          if (ps == RPE_PS_40) begin
            next_hi = lnk.word[`RPE_HI40_HI:0];
          end else begin
            next_hi = {4'h0, lnk.word[`RPE_HI36_HI:0]};
          end
          next_state = RPE_ST_REF_LO;
        end
      end
      RPE_ST_REF_LO: begin
        if (take) begin
          next_addr[ref_idx] = {hi, lnk.word};
          next_hi            = '0;
          if (ref_idx == last_ref) begin
            next_state = (mode == RPE_M_F1) ? RPE_ST_DISP : RPE_ST_TAIL;
          end else begin
            next_ref_idx = ref_idx + 4'h1;
            next_state   = (ps == RPE_PS_32) ? RPE_ST_REF_LO : RPE_ST_REF_HI;
          end
        end
      end
      RPE_ST_TAIL: begin
        if (take) begin
          if (mode == RPE_M_ENC) begin
            next_len_f = lnk.word[`RPE_LEN_B_HI:`RPE_LEN_B_LO];
          end else begin
            next_len_q = lnk.word[`RPE_LEN_A_HI:`RPE_LEN_A_LO];
            next_len_p = lnk.word[`RPE_LEN_B_HI:`RPE_LEN_B_LO];
          end
          next_state = RPE_ST_DISP;
        end
      end
      RPE_ST_DISP: begin
        if (rng_sel) begin
          next_state = RPE_ST_RNG;
        end else if (black && (mode != RPE_M_ENC)) begin
          next_state = RPE_ST_KDEC;
        end else begin
          next_state = RPE_ST_MATH;
        end
      end
      RPE_ST_RNG: begin
        if (rng_done) begin
          next_state = RPE_ST_MATH;
        end
      end
      RPE_ST_KDEC: begin
        if (kdec_done) begin
          next_state = RPE_ST_MATH;
        end
      end
      RPE_ST_MATH: begin
        if (math_done) begin
          if (mode != RPE_M_ENC) begin
            next_scratch = {20'h00000, math_len};
          end
          next_state = RPE_ST_FIN;
        end
      end
      RPE_ST_FIN: begin
        next_state = RPE_ST_IDLE;
      end
      default: begin
        next_state = RPE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= RPE_ST_IDLE;
      mode    <= RPE_M_ENC;
      fmt     <= RPE_FMT_NONE;
      ps      <= RPE_PS_32;
      rng_sel <= 1'b0;
      black   <= 1'b0;
      wrap    <= 2'h0;
      ref_idx <= 4'h0;
      hi      <= 8'h00;
      flags   <= '0;
      len_a   <= '0;
      len_n   <= '0;
      len_f   <= '0;
      len_p   <= '0;
      len_q   <= '0;
      addr    <= '{default: '0};
      scratch <= 32'h00000000;
    end else begin
      state   <= next_state;
      mode    <= next_mode;
      fmt     <= next_fmt;
      ps      <= next_ps;
      rng_sel <= next_rng_sel;
      black   <= next_black;
      wrap    <= next_wrap;
      ref_idx <= next_ref_idx;
      hi      <= next_hi;
      flags   <= next_flags;
      len_a   <= next_len_a;
      len_n   <= next_len_n;
      len_f   <= next_len_f;
      len_p   <= next_len_p;
      len_q   <= next_len_q;
      addr    <= next_addr;
      scratch <= next_scratch;
    end
  end

  // ----------------------------------------------------------------
  // Per-slot argument table
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `RPE_SLOTS; gi++) begin : g_slot
      logic [`RPE_LEN_W-1:0] next_len;
      logic                  next_ind, next_priv;
      always_comb begin
        next_len  = '0;
        next_priv = 1'b0;
        // Slot order follows the reference order of each block layout
        next_ind  = (4'(gi) <= last_ref) ? flags[`RPE_SLOTS-1-gi] : 1'b0;
        case (mode)
          RPE_M_ENC: begin
            case (gi)  // f, g, n, e
              0:       next_len = len_f;
              1, 2:    next_len = len_n;
              3:       next_len = len_a;
              default: next_len = '0;
            endcase
          end
          RPE_M_F1: begin
            case (gi)  // g, f, n, d; n is public
              0, 1, 2: next_len = len_n;
              3: begin
                next_len  = len_a;
                next_priv = 1'b1;
              end
              default: next_len = '0;
            endcase
          end
          RPE_M_F2: begin
            next_priv = (gi >= 2) && (gi <= 4);
            case (gi)  // g, f, d, p, q, buffer one, buffer two
              0, 1:    next_len = len_n;
              2:       next_len = len_a;
              3, 5:    next_len = len_p;
              4, 6:    next_len = len_q;
              default: next_len = '0;
            endcase
          end
          default: begin
            // c, p, q, dp, dq are all private
            next_priv = (gi >= 2) && (gi <= 6);
            case (gi)  // g, f, c, p, q, dp, dq, buffer one, buffer two
              0, 1:       next_len = len_n;
              2, 3, 5, 7: next_len = len_p;
              default:    next_len = len_q;
            endcase
          end
        endcase
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          arg_len[gi]      <= '0;
          arg_indirect[gi] <= 1'b0;
          kdec_mask[gi]    <= 1'b0;
        end else begin
          arg_len[gi]      <= next_len;
          arg_indirect[gi] <= next_ind;
          kdec_mask[gi]    <= next_priv;
        end
      end
      assign arg_addr[gi] = addr[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lnk.word_ready = (state == RPE_ST_HDR) || (state == RPE_ST_W0) ||
                          (state == RPE_ST_REF_HI) || (state == RPE_ST_REF_LO) ||
                          (state == RPE_ST_TAIL);
  assign lnk.done             = (state == RPE_ST_FIN);
  assign lnk.scratch_reg_zero = scratch;
  assign crt_mode = (mode == RPE_M_F3);
  assign rng_req  = (state == RPE_ST_RNG);
  assign rng_len  = len_f;
  assign out_wrap = wrap;
  assign kdec_req = (state == RPE_ST_KDEC);
  // Exponentiation reads input slot 0 and writes output slot 1
  assign math_req = (state == RPE_ST_MATH);
  assign math_dec = (mode != RPE_M_ENC);
  assign pad_en   = (mode == RPE_M_ENC) && (fmt == RPE_FMT_PKCS15);
  assign unpad_en = (mode != RPE_M_ENC) && (fmt == RPE_FMT_PKCS15);

endmodule
`default_nettype wire

//--- logic/rpe_ctrl.sv
// Descriptor controller end: AHB-Lite register slave that streams the parameter block
`timescale 1ns/100ps
`default_nettype none
`include "rpe_cfg.svh"
module rpe_ctrl
  import rpe_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Link to engine
  rpe_link_if.ctrl         lnk
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic       dp_valid, dp_write;
  logic [7:0] dp_addr;
  logic       wr_ctrl, wr_status, wr_count, wr_buf;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  assign wr_ctrl   = dp_valid && dp_write && (dp_addr == `RPE_REG_CTRL);
  assign wr_status = dp_valid && dp_write && (dp_addr == `RPE_REG_STATUS);
  assign wr_count  = dp_valid && dp_write && (dp_addr == `RPE_REG_COUNT);
  assign wr_buf    = dp_valid && dp_write && (dp_addr >= `RPE_REG_BUF);

  // ----------------------------------------------------------------
  // Registers and send sequencer
  // ----------------------------------------------------------------
  logic [31:0] pdb_buf [`RPE_BUF_DEPTH];
  logic [31:0] ctrl, next_ctrl;
  logic [`RPE_CNT_W-1:0] count, next_count, idx, next_idx;
  logic        done, next_done;
  rpe_cstate_t cst, next_cst;

  always_comb begin
    next_ctrl  = ctrl;
    next_count = count;
    next_idx   = idx;
    next_done  = done;
    next_cst   = cst;
    // Start is not stored; a write while busy is ignored and leaves the fields unchanged
    if (wr_ctrl && (cst == RPE_CS_IDLE)) begin
      next_ctrl = {hwdata[31:1], 1'b0};
      if (hwdata[`RPE_C_START]) begin
        next_cst = RPE_CS_START;
      end
    end
    if (wr_count) begin
      next_count = (hwdata[`RPE_CNT_W-1:0] > `RPE_CNT_MAX) ? `RPE_CNT_MAX
                                                           : hwdata[`RPE_CNT_W-1:0];
    end
    if (wr_status && hwdata[`RPE_S_DONE]) begin
      next_done = 1'b0;
    end
    case (cst)
      RPE_CS_IDLE: begin
        next_idx = '0;
      end
      RPE_CS_START: begin
        next_cst = RPE_CS_SEND;
      end
      RPE_CS_SEND: begin
        if (lnk.word_ready && lnk.word_valid) begin
          next_idx = idx + 6'h01;
        end
        if (idx == count) begin
          next_cst = RPE_CS_WAIT;
        end
      end
      RPE_CS_WAIT: begin
        if (lnk.done) begin
          next_cst = RPE_CS_IDLE;
        end
      end
      default: begin
        next_cst = RPE_CS_IDLE;
      end
    endcase
    // Completion wins over a clear in the same cycle
    if (lnk.done) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl  <= 32'h00000000;
      count <= '0;
      idx   <= '0;
      done  <= 1'b0;
      cst   <= RPE_CS_IDLE;
    end else begin
      ctrl  <= next_ctrl;
      count <= next_count;
      idx   <= next_idx;
      done  <= next_done;
      cst   <= next_cst;
    end
  end

  // Buffer holds the descriptor header word first, then the parameter block
  always_ff @(posedge hclk) begin
    if (wr_buf) begin
      pdb_buf[dp_addr[6:2]] <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and link drive
  // ----------------------------------------------------------------
  always_comb begin
    hrdata = 32'h00000000;
    if (dp_valid && !dp_write) begin
      case (dp_addr)
        `RPE_REG_CTRL:    hrdata = ctrl;
        `RPE_REG_STATUS:  hrdata = {30'h00000000, done, cst != RPE_CS_IDLE};
        `RPE_REG_SCRATCH: hrdata = lnk.scratch_reg_zero;
        `RPE_REG_COUNT:   hrdata = {26'h0000000, count};
        default:          hrdata = (dp_addr >= `RPE_REG_BUF) ? pdb_buf[dp_addr[6:2]]
                                                            : 32'h00000000;
      endcase
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign lnk.start      = (cst == RPE_CS_START);
  assign lnk.op         = rpe_op_t'(ctrl[`RPE_C_OP]);
  assign lnk.form       = rpe_form_t'(ctrl[`RPE_C_FORM_HI:`RPE_C_FORM_LO]);
  assign lnk.fmt        = rpe_fmt_t'(ctrl[`RPE_C_FMT]);
  assign lnk.rng_sel    = ctrl[`RPE_C_RNG];
  assign lnk.wrap       = ctrl[`RPE_C_WRAP_HI:`RPE_C_WRAP_LO];
  assign lnk.ps         = rpe_ps_t'(ctrl[`RPE_C_PS_HI:`RPE_C_PS_LO]);
  assign lnk.key_black  = ctrl[`RPE_C_BLACK];
  assign lnk.word_valid = (cst == RPE_CS_SEND) && (idx != count);
  assign lnk.word       = pdb_buf[idx[4:0]];

endmodule
`default_nettype wire

//--- verification/rpe_link_props.sv
// Link checker for the RSA parameter block controller and engine pair
`timescale 1ns/100ps
`default_nettype none
module rpe_link_props
  import rpe_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Link signals
  input wire logic        start,
  input wire rpe_op_t     op,
  input wire rpe_form_t   form,
  input wire rpe_ps_t     ps,
  input wire logic [31:0] word,
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic        done,
  input wire logic [31:0] scratch_reg_zero
);
  logic busy;
  logic next_busy;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------
  // Job in flight, from start to done
  // ------------------------------------------------
  always_comb begin
    next_busy = busy;
    if (start) next_busy = 1'b1;
    else if (done) next_busy = 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) busy <= 1'b0;
    else busy <= next_busy;
  end
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  start_pulse_a: assert property (start |=> !start)
    else $error("start longer than one cycle");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  word_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word))
    else $error("word dropped before taken");
  hdr_taken_a: assert property (start |-> ##[1:4] (word_valid && word_ready))
    else $error("header word not taken after start");
  no_early_done_a: assert property (start |=> !done [*3])
    else $error("done before block parsed");
  scratch_dec_a: assert property ($changed(scratch_reg_zero) |-> op == RPE_OP_DEC)
    else $error("scratch changed outside decrypt");
  ready_busy_a: assert property (word_ready |-> busy)
    else $error("engine ready while idle");
  cfg_stable_a: assert property (busy |-> $stable(op) && $stable(form) && $stable(ps))
    else $error("job settings changed while busy");
  cover property (start && op == RPE_OP_DEC);
  cover property (start && form == RPE_FORM_3);
  cover property (done);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the RSA parameter block controller and engine
`timescale 1ns/100ps
`default_nettype none
`include "rpe_cfg.svh"
module tb_top
  import rpe_pkg::*;
;
  typedef struct {
    logic [31:0] ctl;
    logic [31:0] w1;
    logic [31:0] tail;
    logic [11:0] l2;
    logic [11:0] l3;
    logic [8:0]  kmask;
  } rpe_row_t;
  localparam logic [31:0] A_CTRL = {24'h0, `RPE_REG_CTRL};
  localparam logic [31:0] A_STAT = {24'h0, `RPE_REG_STATUS};
  localparam logic [31:0] A_SCR  = {24'h0, `RPE_REG_SCRATCH};
  logic        hclk, hresetn, hwrite, hreadyout, hresp, crt_mode;
  logic        rng_req, rng_done, kdec_req, kdec_done, math_req, math_done;
  logic        math_dec, pad_en, unpad_en, rng_seen, kdec_seen;
  logic [1:0]  htrans, out_wrap;
  logic [2:0]  m_flags;
  logic [8:0]  arg_indirect, kdec_mask, k_got;
  logic [11:0] rng_len, math_len;
  logic [13:0] r_got;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [`RPE_ADDR_W-1:0] arg_addr [`RPE_SLOTS];
  logic [`RPE_LEN_W-1:0]  arg_len  [`RPE_SLOTS];
  int          num_errors, n_checks;
  rpe_row_t    rows [4];
  rpe_link_if lnk ();
  rpe_ctrl u_rpe_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .lnk(lnk.ctrl));
  rpe_engine u_rpe_engine (.hclk, .hresetn, .lnk(lnk.device), .arg_addr, .arg_len, .arg_indirect,
    .crt_mode, .rng_req, .rng_len, .out_wrap, .rng_done, .kdec_req, .kdec_mask, .kdec_done,
    .math_req, .math_dec, .pad_en, .unpad_en, .math_done, .math_len);
  rpe_link_props u_props (.hclk(hclk), .hresetn(hresetn), .start(lnk.start), .op(lnk.op),
    .form(lnk.form), .ps(lnk.ps), .word(lnk.word), .word_valid(lnk.word_valid),
    .word_ready(lnk.word_ready), .done(lnk.done), .scratch_reg_zero(lnk.scratch_reg_zero));
  // ------------------------------------------------
  // Prompt responders for random, unwrap and math units
  // ------------------------------------------------
  always @(posedge hclk) begin
    if (!hresetn || lnk.start) begin
      {rng_done, kdec_done, math_done, rng_seen, kdec_seen} <= '0;
    end else begin
      rng_done <= rng_req && !rng_done;
      kdec_done <= kdec_req && !kdec_done;
      math_done <= math_req && !math_done;
      if (rng_req) begin
        rng_seen <= 1'b1;
        r_got <= {rng_len, out_wrap};
      end
      if (kdec_req) begin
        kdec_seen <= 1'b1;
        k_got <= kdec_mask;
      end
      if (math_req) m_flags <= {math_dec, pad_en, unpad_en};
    end
  end
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    @(negedge hclk);
    for (n = 0; n < 16 && hreadyout !== 1'b1; n++) @(negedge hclk);
    if (n == 16) begin
      num_errors++;
      end_of_test();
    end
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic run_row(input rpe_row_t rw);
    logic [31:0] q [$];
    logic [1:0]  fm, ps;
    logic        op;
    int          nref, n;
    op = rw.ctl[`RPE_C_OP];
    fm = rw.ctl[3:2];
    ps = rw.ctl[9:8];
    nref = (!op || fm == 2'd0) ? 4 : (fm == 2'd1 ? 7 : 9);
    q = '{32'hB000_0000, rw.w1};
    for (n = 0; n < nref; n++) begin
      if (ps != 2'd0) q.push_back(32'hFFFF_FF50 | 32'(n));
      q.push_back(32'h8000_0000 | 32'(n << 4));
    end
    if (!(op && fm == 2'd0)) q.push_back(rw.tail);
    for (n = 0; n < q.size(); n++) ahb(1'b1, {24'h0, `RPE_REG_BUF} + 32'(4 * n), q[n]);
    ahb(1'b1, {24'h0, `RPE_REG_COUNT}, 32'(q.size()));
    math_len <= rw.l2 + 12'h001;
    ahb(1'b1, A_CTRL, rw.ctl);
    ahb(1'b1, A_CTRL, 32'h0);
    rd = 32'h0;
    for (n = 0; n < 60 && rd[`RPE_S_DONE] !== 1'b1; n++) ahb(1'b0, A_STAT, 32'h0);
    chk(rd[1:0], 2'b10);
    for (n = 0; n < 9; n++) begin
      if (n < nref) chk(arg_addr[n], {(ps == 2'd2) ? 4'h5 : 4'h0, (ps == 2'd0) ? 4'h0 : n[3:0],
        32'h8000_0000 | 32'(n << 4)});
      chk(arg_indirect[n], n < nref ? rw.w1[31 - n] : 1'b0);
    end
    chk(arg_len[2], rw.l2);
    chk(arg_len[3], rw.l3);
    if (op && fm != 2'd0)
      chk({arg_len[5], arg_len[6]}, {rw.tail[11:0], rw.tail[23:12]});
    chk(crt_mode, op && fm == 2'd2);
    chk(m_flags, {op, !op && rw.ctl[4], op && rw.ctl[4]});
    chk(rng_seen ? r_got : 14'h0, rw.ctl[5] ? {rw.tail[11:0], rw.ctl[7:6]} : 14'h0);
    chk(kdec_seen ? k_got : 9'h0, rw.kmask);
    if (op) ahb(1'b0, A_SCR, 32'h0);
    if (op) chk(rd, rw.l2 + 12'h001);
    ahb(1'b1, A_STAT, 32'h2);
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd[1], 1'b0);
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    {hresetn, htrans, haddr, hwrite, hwdata, rd, math_len} = '0;
    num_errors = 0;
    n_checks = 0;
    rows = '{
      '{32'h0000_00B1, 32'hA500_3100, 32'hFFF0_00F0, 12'h100, 12'h003, 9'h000},
      '{32'h0000_0503, 32'h5008_0100, 32'h0000_0000, 12'h100, 12'h080, 9'h008},
      '{32'h0000_0217, 32'hAB04_0080, 32'hCC02_0030, 12'h040, 12'h030, 9'h000},
      '{32'h0000_040B, 32'hD2FF_F100, 32'hFF02_0030, 12'h030, 12'h030, 9'h07C}};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0040, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, A_SCR, 32'hFFFF_FFFF);
    ahb(1'b0, A_SCR, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[r]) run_row(rows[r]);
    // Second reset must clear the kept plaintext length
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, A_SCR, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
